// file: hdl/pdi2c_pkg.sv
// Constants, states and carrier types of the power-delivery I2C target port.
// Assumes a single core clock well above the bus bit rate and a synchronous reset.
//
// Behaviour
// - Works at standard and fast mode bus rates by oversampling both lines.
// - SDA falling while SCL high is a start; then an address byte follows.
// - A matching address is acknowledged by holding SDA low in the ninth pulse.
// - One bit per pulse; SDA changes only while SCL is low.
// - SDA rising while SCL high is a stop and ends the transfer.
// - Any number of bytes; each byte has exactly one acknowledge slot.
// - The transmitter releases SDA before the acknowledge slot.
// - Every byte written to this target is acknowledged.
// - After a host NACK the target releases SDA and waits for stop or start.
// - The target holds SCL low while it cannot take or supply a byte.
// - Stretching may fall on any pulse and logic tolerates it.
// - Address is fixed at boot from two select pins before responding.
// - Select pins are sampled as static levels, not edges.
// - A loaded event mask gates events onto the active-low interrupt.
// - First written byte is the sub-address; later bytes are command data.

package pdi2c_pkg;

    // ==========================================================
    // Addressing
    // ==========================================================
    localparam logic [4:0] PDI2C_ADDR_BASE = 5'h0E;
    localparam int PDI2C_ADDR_SEL_LSB = 0;
    localparam int PDI2C_ADDR_BASE_LSB = 2;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int PDI2C_CLK_MHZ = 100;
    localparam int PDI2C_BOOT_NS = 100;
    localparam int PDI2C_BOOT_CYCLES = (PDI2C_BOOT_NS * PDI2C_CLK_MHZ + 999) / 1000;
    localparam int PDI2C_HOST_HIGH_US = 4;

    // ==========================================================
    // Sizes and reset values
    // ==========================================================
    localparam int PDI2C_EVENTS = 8;
    localparam int PDI2C_FIFO_DEPTH = 32;
    localparam logic [7:0] PDI2C_BYTE_RESET = 8'h00;
    localparam logic [2:0] PDI2C_LAST_BIT = 3'h7;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [2:0] {
        PDI2C_IDLE,
        PDI2C_ADDR,
        PDI2C_ADDR_ACK,
        PDI2C_WR_BYTE,
        PDI2C_WR_PUSH,
        PDI2C_WR_ACK,
        PDI2C_RD_LOAD,
        PDI2C_RD_BYTE
    } pdi2c_state_type;

    typedef struct packed {
        logic is_sub;
        logic [7:0] data;
    } pdi2c_rx_type;

    localparam int PDI2C_RX_WIDTH = $bits(pdi2c_rx_type);

endpackage

// file: hdl/pdi2c_target.sv
// Receive FIFO and the I2C target port of the power-delivery controller.
// Assumes SCL and SDA arrive asynchronously and are open-drain with external pull-ups.
`timescale 1ns/10ps

// ==========================================================
// Receive FIFO with registered output stage
// ==========================================================
module pdi2c_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;

    wire full = (count == (AW+1)'(DEPTH));
    wire empty = (count == '0);
    wire push = in_valid_i && !full;
    wire pop = !empty && (!out_valid_o || out_ready_i);

    assign in_ready_o = !full;

    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            out_valid_o <= 1'b0;
            out_data_o <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
                out_data_o <= mem[rd_ptr];
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
            if (pop) begin
                out_valid_o <= 1'b1;
            end else if (out_ready_i) begin
                out_valid_o <= 1'b0;
            end
        end
    end
endmodule

// ==========================================================
// I2C target port
// ==========================================================
module pdi2c_target (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic addr_select_pin_a,
    input wire logic addr_select_pin_b,
    output logic [6:0] own_addr_o,
    output logic addr_valid_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    output pdi2c_pkg::pdi2c_rx_type rx_data_o,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire logic [7:0] tx_data_i,
    output logic stop_o,
    input wire logic [pdi2c_pkg::PDI2C_EVENTS-1:0] event_i,
    input wire logic [pdi2c_pkg::PDI2C_EVENTS-1:0] event_mask_i,
    input wire logic mask_load_i,
    output logic host_irq_n
);
    // ==========================================================
    // Synchronisers and line events
    // ==========================================================
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [1:0] pin_a_sync;
    logic [1:0] pin_b_sync;
    logic scl_q;
    logic sda_q;

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            pin_a_sync <= 2'h0;
            pin_b_sync <= 2'h0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_i};
            sda_sync <= {sda_sync[0], sda_i};
            pin_a_sync <= {pin_a_sync[0], addr_select_pin_a};
            pin_b_sync <= {pin_b_sync[0], addr_select_pin_b};
            scl_q <= scl_sync[1];
            sda_q <= sda_sync[1];
        end
    end

    // Oversampling at the core clock keeps edge decisions well inside fast-mode bit times.
    wire scl = scl_sync[1];
    wire sda = sda_sync[1];
    wire scl_rise = scl && !scl_q;
    wire scl_fall = !scl && scl_q;
    wire start_seen = scl && scl_q && sda_q && !sda;
    wire stop_seen = scl && scl_q && !sda_q && sda;

    // ==========================================================
    // Boot-time address capture
    // ==========================================================
    logic [3:0] boot_cnt;
    wire boot_done = (boot_cnt == 4'(pdi2c_pkg::PDI2C_BOOT_CYCLES));

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            boot_cnt <= 4'h0;
            addr_valid_o <= 1'b0;
            own_addr_o <= 7'h00;
        end else if (!addr_valid_o) begin
            if (boot_done) begin
                // Levels are taken once from the settled synchronisers; edges play no part.
                addr_valid_o <= 1'b1;
                own_addr_o <= {pdi2c_pkg::PDI2C_ADDR_BASE, pin_b_sync[1], pin_a_sync[1]};
            end else begin
                boot_cnt <= boot_cnt + 4'h1;
            end
        end
    end

    // ==========================================================
    // Protocol engine
    // ==========================================================
    pdi2c_pkg::pdi2c_state_type state;
    pdi2c_pkg::pdi2c_state_type next_state;
    logic [7:0] shift;
    logic [7:0] next_shift;
    logic [2:0] bit_cnt;
    logic [2:0] next_bit_cnt;
    logic first_byte;
    logic next_first_byte;
    logic next_sda_oe_n;
    logic next_scl_oe_n;
    logic nacked;
    logic next_nacked;
    logic skip_fall;
    logic next_skip_fall;

    wire fifo_in_ready;
    wire tx_take = tx_ready_o && tx_valid_i;
    wire addr_match = (shift[7:1] == own_addr_o);
    wire push_req = (state == pdi2c_pkg::PDI2C_WR_PUSH);
    wire push_ok = push_req && fifo_in_ready;
    wire next_tx_ready = (state == pdi2c_pkg::PDI2C_RD_LOAD) && !tx_take;
    pdi2c_pkg::pdi2c_rx_type rx_word;

    assign rx_word.is_sub = first_byte;
    assign rx_word.data = shift;

    always_comb begin
        next_state = state;
        next_shift = shift;
        next_bit_cnt = bit_cnt;
        next_first_byte = first_byte;
        next_sda_oe_n = sda_oe_n_o;
        next_scl_oe_n = scl_oe_n_o;
        next_nacked = nacked;
        next_skip_fall = skip_fall;
        if (stop_seen) begin
            next_state = pdi2c_pkg::PDI2C_IDLE;
            next_sda_oe_n = 1'b1;
            next_scl_oe_n = 1'b1;
        end else if (start_seen && addr_valid_o) begin
            // A start at any point abandons the byte in flight.
            next_state = pdi2c_pkg::PDI2C_ADDR;
            next_bit_cnt = 3'h0;
            // The SCL fall that closes the start carries no bit and is not counted.
            next_skip_fall = 1'b1;
            next_sda_oe_n = 1'b1;
            next_scl_oe_n = 1'b1;
        end else begin
            case (state)
                pdi2c_pkg::PDI2C_IDLE: begin
                    next_sda_oe_n = 1'b1;
                end
                pdi2c_pkg::PDI2C_ADDR, pdi2c_pkg::PDI2C_WR_BYTE: begin
                    if (scl_rise) begin
                        next_shift = {shift[6:0], sda};
                    end
                    if (scl_fall && skip_fall) begin
                        next_skip_fall = 1'b0;
                    end else if (scl_fall) begin
                        next_bit_cnt = bit_cnt + 3'h1;
                        if (bit_cnt == pdi2c_pkg::PDI2C_LAST_BIT) begin
                            if (state == pdi2c_pkg::PDI2C_WR_BYTE) begin
                                next_scl_oe_n = 1'b0;
                                next_state = pdi2c_pkg::PDI2C_WR_PUSH;
                            end else if (addr_match) begin
                                next_sda_oe_n = 1'b0;
                                next_state = pdi2c_pkg::PDI2C_ADDR_ACK;
                            end else begin
                                next_state = pdi2c_pkg::PDI2C_IDLE;
                            end
                        end
                    end
                end
                pdi2c_pkg::PDI2C_ADDR_ACK: begin
                    if (scl_fall) begin
                        next_sda_oe_n = 1'b1;
                        next_bit_cnt = 3'h0;
                        next_first_byte = 1'b1;
                        if (shift[0]) begin
                            next_scl_oe_n = 1'b0;
                            next_state = pdi2c_pkg::PDI2C_RD_LOAD;
                        end else begin
                            next_state = pdi2c_pkg::PDI2C_WR_BYTE;
                        end
                    end
                end
                pdi2c_pkg::PDI2C_WR_PUSH: begin
                    if (push_ok) begin
                        next_sda_oe_n = 1'b0;
                        next_scl_oe_n = 1'b1;
                        next_first_byte = 1'b0;
                        next_state = pdi2c_pkg::PDI2C_WR_ACK;
                    end
                end
                pdi2c_pkg::PDI2C_WR_ACK: begin
                    if (scl_fall) begin
                        next_sda_oe_n = 1'b1;
                        next_bit_cnt = 3'h0;
                        next_state = pdi2c_pkg::PDI2C_WR_BYTE;
                    end
                end
                pdi2c_pkg::PDI2C_RD_LOAD: begin
                    if (tx_take) begin
                        next_shift = tx_data_i;
                        next_sda_oe_n = tx_data_i[7];
                        next_bit_cnt = 3'h0;
                        next_nacked = 1'b0;
                        next_state = pdi2c_pkg::PDI2C_RD_BYTE;
                    end
                end
                pdi2c_pkg::PDI2C_RD_BYTE: begin
                    // SCL is let go one cycle after the first bit is set up on SDA.
                    next_scl_oe_n = 1'b1;
                    if (bit_cnt == 3'h0 && nacked) begin
                        // Ninth pulse: sample the host answer, SDA already released.
                        if (scl_fall) begin
                            next_state = pdi2c_pkg::PDI2C_RD_LOAD;
                            next_scl_oe_n = 1'b0;
                        end
                    end else if (scl_fall) begin
                        next_bit_cnt = bit_cnt + 3'h1;
                        next_shift = {shift[6:0], 1'b1};
                        if (bit_cnt == pdi2c_pkg::PDI2C_LAST_BIT) begin
                            next_sda_oe_n = 1'b1;
                            next_nacked = 1'b1;
                        end else begin
                            next_sda_oe_n = shift[6];
                        end
                    end else if (scl_rise && bit_cnt == 3'h0 && first_byte == 1'b0) begin
                        next_nacked = nacked;
                    end
                end
                default: begin
                    next_state = pdi2c_pkg::PDI2C_IDLE;
                end
            endcase
        end
    end

    // The acknowledge slot of a read is watched here; a high SDA is a NACK.
    logic ack_wait;
    wire ack_slot_rise = (state == pdi2c_pkg::PDI2C_RD_BYTE) && nacked && scl_rise;

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            ack_wait <= 1'b0;
        end else if (ack_slot_rise) begin
            ack_wait <= sda;
        end else if (state != pdi2c_pkg::PDI2C_RD_BYTE) begin
            ack_wait <= 1'b0;
        end
    end

    wire host_nack = ack_wait && (state == pdi2c_pkg::PDI2C_RD_BYTE) && nacked && scl_fall;

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            state <= pdi2c_pkg::PDI2C_IDLE;
            shift <= pdi2c_pkg::PDI2C_BYTE_RESET;
            bit_cnt <= 3'h0;
            first_byte <= 1'b0;
            nacked <= 1'b0;
            skip_fall <= 1'b0;
            sda_oe_n_o <= 1'b1;
            scl_oe_n_o <= 1'b1;
            tx_ready_o <= 1'b0;
            stop_o <= 1'b0;
        end else begin
            // After a host NACK the line stays released until stop or start.
            state <= (host_nack && !stop_seen && !start_seen) ? pdi2c_pkg::PDI2C_IDLE : next_state;
            scl_oe_n_o <= (host_nack && !start_seen) ? 1'b1 : next_scl_oe_n;
            shift <= next_shift;
            bit_cnt <= next_bit_cnt;
            first_byte <= next_first_byte;
            nacked <= next_nacked;
            skip_fall <= next_skip_fall;
            sda_oe_n_o <= next_sda_oe_n;
            tx_ready_o <= next_tx_ready;
            stop_o <= stop_seen && (state != pdi2c_pkg::PDI2C_IDLE);
        end
    end

    // Both pins only ever pull low.
    always_ff @(posedge mclk_i) begin
        scl_o <= 1'b0;
        sda_o <= 1'b0;
    end

    // ==========================================================
    // Receive buffer
    // ==========================================================
    pdi2c_fifo #(
        .WIDTH(pdi2c_pkg::PDI2C_RX_WIDTH),
        .DEPTH(pdi2c_pkg::PDI2C_FIFO_DEPTH)
    ) u_rx_fifo (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(push_req),
        .in_ready_o(fifo_in_ready),
        .in_data_i(rx_word),
        .out_valid_o(rx_valid_o),
        .out_ready_i(rx_ready_i),
        .out_data_o(rx_data_o)
    );

    // ==========================================================
    // Host interrupt
    // ==========================================================
    logic [pdi2c_pkg::PDI2C_EVENTS-1:0] irq_mask;

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            irq_mask <= '0;
            host_irq_n <= 1'b1;
        end else begin
            if (mask_load_i) begin
                irq_mask <= event_mask_i;
            end
            host_irq_n <= ~|(event_i & irq_mask);
        end
    end
endmodule

// file: bench/pdi2c_target_chk.sv
// Concurrent checks on the ports of the I2C target port, attached by bind.
// Assumes scl_i carries the resolved open-drain wire level.
`timescale 1ns/10ps
module pdi2c_target_chk (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic scl_i,
    input wire logic scl_oe_n_o,
    input wire logic sda_oe_n_o,
    input wire logic [6:0] own_addr_o,
    input wire logic addr_valid_o,
    input wire logic rx_valid_o,
    input wire logic rx_ready_i,
    input wire pdi2c_pkg::pdi2c_rx_type rx_data_o,
    input wire logic stop_o,
    input wire logic [pdi2c_pkg::PDI2C_EVENTS-1:0] event_i,
    input wire logic host_irq_n
);
    // ==========================================================
    // Properties
    // ==========================================================
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    property p_addr_base;
        addr_valid_o |-> own_addr_o[6:2] == pdi2c_pkg::PDI2C_ADDR_BASE;
    endproperty
    a_addr_base: assert property (p_addr_base) else $error("address base wrong");
    property p_addr_fixed;
        addr_valid_o |=> addr_valid_o && $stable(own_addr_o);
    endproperty
    a_addr_fixed: assert property (p_addr_fixed) else $error("address moved");
    property p_silent_boot;
        !addr_valid_o |-> sda_oe_n_o && scl_oe_n_o;
    endproperty
    a_silent_boot: assert property (p_silent_boot) else $error("bus driven early");
    property p_sda_low_scl;
        $changed(sda_oe_n_o) |-> !$past(scl_i);
    endproperty
    a_sda_low_scl: assert property (p_sda_low_scl) else $error("SDA moved, SCL high");
    // An acknowledge must outlast the rest of the low phase and the high phase.
    property p_ack_hold;
        $fell(sda_oe_n_o) |=> !sda_oe_n_o [*4];
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("SDA low too short");
    property p_stretch_low;
        $fell(scl_oe_n_o) |-> !$past(scl_i);
    endproperty
    a_stretch_low: assert property (p_stretch_low) else $error("stretch cut a pulse");
    property p_stop_pulse;
        stop_o |=> !stop_o;
    endproperty
    a_stop_pulse: assert property (p_stop_pulse) else $error("stop pulse long");
    property p_rx_hold;
        rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o);
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("rx word dropped");
    property p_irq_quiet;
        !(|event_i) |=> host_irq_n;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq with no event");
    c_stop: cover property (stop_o);
    c_stretch: cover property (!scl_oe_n_o);
    c_pop: cover property (rx_valid_o && rx_ready_i);
endmodule

bind pdi2c_target pdi2c_target_chk pdi2c_target_chk_inst (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .scl_i(scl_i), .scl_oe_n_o(scl_oe_n_o),
    .sda_oe_n_o(sda_oe_n_o), .own_addr_o(own_addr_o), .addr_valid_o(addr_valid_o),
    .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i), .rx_data_o(rx_data_o),
    .stop_o(stop_o), .event_i(event_i), .host_irq_n(host_irq_n)
);

// file: bench/pdi2c_host.sv
// Behavioural I2C host that drives the bus side of the target port.
// Assumes the bench resolves the open-drain wires; an output at 1 releases its line.
`timescale 1ns/10ps
module pdi2c_host #(
    parameter int Q_NS = 20
) (
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    logic hang = 1'b0;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // Releases SCL, then waits while the target holds it low.
    task automatic rise();
        int n;
        scl_o = 1'b1;
        n = 0;
        while (!scl_i && n < 20000) begin
            #1;
            n++;
        end
        if (!scl_i) hang = 1'b1;
        #(Q_NS);
    endtask
    task automatic bit_io(input logic b, output logic r);
        #(Q_NS) sda_o = b;
        #(Q_NS) rise();
        r = sda_i;
        #(Q_NS) scl_o = 1'b0;
    endtask
    task automatic start();
        #(Q_NS) sda_o = 1'b1;
        #(Q_NS) rise();
        sda_o = 1'b0;
        #(Q_NS) scl_o = 1'b0;
    endtask
    task automatic stop();
        #(Q_NS) sda_o = 1'b0;
        #(Q_NS) rise();
        sda_o = 1'b1;
        #(Q_NS);
    endtask
    task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q,
                        output logic a);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(ai, a);
    endtask
endmodule

// file: bench/pdi2c_target_test.sv
// Self-checking bench for the I2C target port with a behavioural bus host.
// Assumes a 100 MHz core clock and an 80 ns link bit period.
`timescale 1ns/10ps
module pdi2c_target_test;
    localparam logic [6:0] ME = {pdi2c_pkg::PDI2C_ADDR_BASE, 2'h1};
    logic mclk, rst_b, scl_oe_n, sda_oe_n, h_scl, h_sda, pin_a, pin_b;
    logic addr_valid, rx_valid, rx_ready, tx_valid, tx_ready, stop, mask_load, irq_n;
    logic [6:0] own_addr;
    logic [1:0] pin_lo;
    logic [7:0] tx_data, ev, mask;
    pdi2c_pkg::pdi2c_rx_type rx_data;
    int n_mismatch = 0, total_checks = 0, stops = 0;
    wire logic scl_w = h_scl & scl_oe_n;
    wire logic sda_w = h_sda & sda_oe_n;
    pdi2c_target pdi2c_target_inst (
        .mclk_i(mclk), .rst_b_i(rst_b), .scl_i(scl_w), .scl_o(pin_lo[1]), .scl_oe_n_o(scl_oe_n),
        .sda_i(sda_w), .sda_o(pin_lo[0]), .sda_oe_n_o(sda_oe_n), .addr_select_pin_a(pin_a),
        .addr_select_pin_b(pin_b), .own_addr_o(own_addr), .addr_valid_o(addr_valid),
        .rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .rx_data_o(rx_data),
        .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .tx_data_i(tx_data), .stop_o(stop),
        .event_i(ev), .event_mask_i(mask), .mask_load_i(mask_load), .host_irq_n(irq_n)
    );
    pdi2c_host pdi2c_host_inst (.scl_i(scl_w), .sda_i(sda_w), .scl_o(h_scl), .sda_o(h_sda));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (stop) stops++;
        if (tx_valid && tx_ready) tx_data <= ~tx_data;
    end
    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic tmo(input logic bad);
        if (bad) begin
            n_mismatch++;
            $display("BAD wait expected done seen timeout");
            results();
        end
    endtask
    task automatic hbyte(input logic [7:0] d, input logic ai, input logic ae,
                         output logic [7:0] q);
        logic a;
        pdi2c_host_inst.xfer(d, ai, q, a);
        tmo(pdi2c_host_inst.hang);
        chk("ack", ae, a);
    endtask
    task automatic pop(input logic [8:0] e);
        int n;
        n = 0;
        while (!rx_valid && n < 500) begin
            tick(1);
            n++;
        end
        tmo(!rx_valid);
        chk("rx", e, rx_data);
        rx_ready = 1'b1;
        tick(1);
        rx_ready = 1'b0;
    endtask
    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_boot();
        int n;
        n = 0;
        while (!addr_valid && n < 100) begin
            tick(1);
            n++;
        end
        tmo(!addr_valid);
        chk("own_addr", ME, own_addr);
        chk("pin_lo", 2'h0, pin_lo);
        $display("test boot done");
    endtask
    task automatic t_write();
        logic [7:0] q;
        int s0;
        pdi2c_host_inst.start();
        hbyte({ME, 1'b0}, 1'b1, 1'b0, q);
        hbyte(8'hA5, 1'b1, 1'b0, q);
        hbyte(8'h3C, 1'b1, 1'b0, q);
        s0 = stops;
        pdi2c_host_inst.stop();
        tick(5);
        chk("stop", s0 + 1, stops);
        pop({1'b1, 8'hA5});
        pop({1'b0, 8'h3C});
        $display("test write done");
    endtask
    task automatic t_nomatch();
        logic [7:0] q;
        pdi2c_host_inst.start();
        hbyte({ME ^ 7'h04, 1'b0}, 1'b1, 1'b1, q);
        hbyte(8'h55, 1'b1, 1'b1, q);
        pdi2c_host_inst.stop();
        tick(10);
        chk("rx_valid", 1'b0, rx_valid);
        $display("test nomatch done");
    endtask
    // The sub-address write is cut by a start mid-byte, then read back in SMBus framing.
    task automatic t_read();
        logic [7:0] q;
        logic b;
        pdi2c_host_inst.start();
        hbyte({ME, 1'b0}, 1'b1, 1'b0, q);
        repeat (3) pdi2c_host_inst.bit_io(1'b1, b);
        pdi2c_host_inst.start();
        hbyte({ME, 1'b0}, 1'b1, 1'b0, q);
        hbyte(8'h12, 1'b1, 1'b0, q);
        pdi2c_host_inst.start();
        tx_data = 8'h81;
        fork
            hbyte({ME, 1'b1}, 1'b1, 1'b0, q);
            begin
                tick(120);
                chk("scl_oe_n", 1'b0, scl_oe_n);
                tx_valid = 1'b1;
            end
        join
        hbyte(8'hFF, 1'b0, 1'b0, q);
        chk("rd", 8'h81, q);
        hbyte(8'hFF, 1'b1, 1'b1, q);
        chk("rd", 8'h7E, q);
        tx_valid = 1'b0;
        tick(2);
        chk("sda_oe_n", 1'b1, sda_oe_n);
        pdi2c_host_inst.stop();
        pop({1'b1, 8'h12});
        tick(5);
        chk("rx_valid", 1'b0, rx_valid);
        $display("test read done");
    endtask
    // The receive buffer holds 33 words; the 34th byte must be stretched until the first word is popped.
    task automatic t_fill();
        logic [7:0] q;
        pdi2c_host_inst.start();
        hbyte({ME, 1'b0}, 1'b1, 1'b0, q);
        fork
            for (int i = 0; i < 34; i++) hbyte(8'(i), 1'b1, 1'b0, q);
            begin
                tick(2900);
                chk("scl_oe_n", 1'b0, scl_oe_n);
                for (int i = 0; i < 34; i++) pop({i == 0, 8'(i)});
            end
        join
        pdi2c_host_inst.stop();
        $display("test fill done");
    endtask
    task automatic t_irq();
        mask = 8'h0F;
        mask_load = 1'b1;
        tick(1);
        mask_load = 1'b0;
        ev = 8'h10;
        tick(3);
        chk("irq_n", 1'b1, irq_n);
        ev = 8'h04;
        tick(2);
        chk("irq_n", 1'b0, irq_n);
        ev = 8'h00;
        tick(2);
        chk("irq_n", 1'b1, irq_n);
        $display("test irq done");
    endtask
    initial begin
        {rst_b, rx_ready, tx_valid, mask_load, pin_b} = 5'h00;
        pin_a = 1'b1;
        tx_data = 8'h00;
        ev = 8'h00;
        mask = 8'h00;
        tick(2);
        rst_b = 1'b1;
        t_boot();
        t_write();
        t_nomatch();
        t_read();
        t_fill();
        t_irq();
        results();
    end
endmodule
